// ==== shared/cmac_pkg.sv ====
// Summary of operation
// - Every location of all three memories holds one 18-bit word.
// - Control memory 128 words, bootstrap 32, main 16K to 64K in 16K steps.
// - Each main or control access selects address, reads the word, then writes at that address.
// - Destructive reads force a write-back of the read or replacement word.
// - Bootstrap reads are nondestructive and never get a write cycle.
// - The 16-bit main address register loads from one of four sources.
// - Main read data lands in main data register; write cycle stores it.
// - The 8-bit control address register loads from one of four sources.
// - Control reads fill control data register; write may store it back.
// - Main cycle is two microseconds with data ready by 750 ns; here read, gap and write take 41 clocks, 2050 ns.
// - A bank is four stacks of 4096 words, one plane per bit.
// - Decode one of four banks, four stacks, 64 X-lines and 64 Y-lines.
// - Address bits 14 and 15 pick the bank; bits 0 to 13 go to memory.
// - Special external selections set address bit 0, 6 or 8 in phase 1.
// - Bank select and timing give separate read and write enables per bank.
// - In a write, each zero data bit asserts its plane inhibit.
// - Address bits 6 to 8 select one of eight X-line groups.
// - Address bits 9 to 11 select one of eight X-lines in the group.
// - Bits 0-2 pick Y group, 3-5 the Y line, 12-13 the stack.
package cmac_pkg;
  localparam int WORD_W = 18;
  localparam int MAIN_AW = 16;
  localparam int CTL_AW = 8;
  localparam int CTL_WORDS = 128;
  localparam int BOOT_WORDS = 32;
  localparam int BANK_WORDS = 16384;
  localparam int STACK_WORDS = 4096;
  localparam int CLK_MHZ = 20;
  localparam int CYCLE_NS = 2000;
  localparam int ACCESS_NS = 750;
  // Read phase ends at the access limit; the rest of the full cycle writes.
  localparam int READ_CYC = (ACCESS_NS * CLK_MHZ) / 1000;
  localparam int FULL_CYC = (CYCLE_NS * CLK_MHZ) / 1000;
  localparam int WRITE_CYC = FULL_CYC - READ_CYC;
  localparam int BIT_YGRP = 0;
  localparam int BIT_YLINE = 3;
  localparam int BIT_XGRP = 6;
  localparam int BIT_XLINE = 9;
  localparam int BIT_STACK = 12;
  localparam int BIT_BANK = 14;
  localparam int SPECIAL0 = 0;
  localparam int SPECIAL6 = 6;
  localparam int SPECIAL8 = 8;
  // Address sources.
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_C = 2'h2;
  localparam logic [1:0] SRC_D = 2'h3;
  localparam logic [WORD_W-1:0] DATA_RST = 18'h00000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_GAP = 4'h4,
    ST_WRITE = 4'h8
  } cmac_state_e;
endpackage

// ==== design/cmac_core.sv ====
`timescale 1ns/1ns
module cmac_core #(
  parameter int BANKS = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  // Main memory request.
  input wire logic mainStart,
  input wire logic [1:0] mainSrcSel,
  input wire logic [15:0] progCounter,
  input wire logic [15:0] indexReg,
  input wire logic [15:0] ioAddr,
  input wire logic [15:0] adderAddr,
  input wire logic [2:0] specialSel,
  input wire logic mainReplace,
  input wire logic [17:0] mainNewData,
  input wire logic [17:0] mainSense,
  // Control and bootstrap request.
  input wire logic ctlStart,
  input wire logic [1:0] ctlSrcSel,
  input wire logic [7:0] indexCtlReg,
  input wire logic [7:0] ioCtlAddr,
  input wire logic [7:0] arithCtlAddr,
  input wire logic ctlReplace,
  input wire logic [17:0] ctlNewData,
  input wire logic [17:0] ctlSense,
  input wire logic [17:0] bootWord,
  // Outputs, all registered.
  output logic [15:0] main_addr_reg,
  output logic [17:0] main_data_reg,
  output logic [3:0] bankReadEn,
  output logic [3:0] bankWriteEn,
  output logic [3:0] stackSel,
  output logic [7:0] xGroupSel,
  output logic [7:0] xLineSel,
  output logic [7:0] yGroupSel,
  output logic [7:0] yLineSel,
  output logic [17:0] inhibit,
  output logic mainBusy,
  output logic mainDone,
  output logic [7:0] ctl_addr_reg,
  output logic [17:0] ctl_data_reg,
  output logic ctlReadEn,
  output logic ctlWriteEn,
  output logic [17:0] ctlInhibit,
  output logic bootReadEn,
  output logic ctlBusy,
  output logic ctlDone
);
  localparam int RC = cmac_pkg::READ_CYC;
  localparam int WC = cmac_pkg::WRITE_CYC;
  localparam logic [6:0] RC_M1 = 7'(RC - 1);
  localparam logic [6:0] WC_M1 = 7'(WC - 1);

  initial begin
    if (BANKS < 1 || BANKS > 4) $error("BANKS must be 1 to 4");
    if (RC < 1 || WC < 1 || RC + WC > 127) $error("cycle counts out of range");
  end

  // One-hot decode of a three-bit field, used for every line and group select.
  function automatic logic [7:0] dec8(input logic [2:0] v);
    dec8 = 8'h01 << v;
  endfunction

  function automatic logic [3:0] dec4(input logic [1:0] v);
    dec4 = 4'h1 << v;
  endfunction

  cmac_pkg::cmac_state_e mainSt_q;
  cmac_pkg::cmac_state_e ctlSt_q;
  logic [6:0] mainCnt_q;
  logic [6:0] ctlCnt_q;
  logic isBoot_q;
  logic [15:0] mainSrc;
  logic [7:0] ctlSrc;
  logic [3:0] bankHot;
  logic bankOk;
  logic [15:0] mainAddrD;

  // Address source multiplexers.
  always_comb begin
    case (mainSrcSel)
      cmac_pkg::SRC_A: mainSrc = progCounter;
      cmac_pkg::SRC_B: mainSrc = indexReg;
      cmac_pkg::SRC_C: mainSrc = ioAddr;
      default: mainSrc = adderAddr;
    endcase
    case (ctlSrcSel)
      cmac_pkg::SRC_A: ctlSrc = main_addr_reg[7:0];
      cmac_pkg::SRC_B: ctlSrc = indexCtlReg;
      cmac_pkg::SRC_C: ctlSrc = ioCtlAddr;
      default: ctlSrc = arithCtlAddr;
    endcase
  end

  // Bank select from the top two bits; absent banks get no enables.
  assign bankHot = dec4(main_addr_reg[cmac_pkg::BIT_BANK +: 2]);
  assign bankOk = 32'(main_addr_reg[cmac_pkg::BIT_BANK +: 2]) < BANKS;

  // Main sequencer: idle, read, one-cycle gap, write, back to idle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mainSt_q <= cmac_pkg::ST_IDLE;
      mainCnt_q <= 7'h00;
    end else begin
      case (mainSt_q)
        cmac_pkg::ST_IDLE: begin
          mainCnt_q <= 7'h00;
          if (mainStart) begin
            mainSt_q <= cmac_pkg::ST_READ;
          end
        end
        cmac_pkg::ST_READ: begin
          if (mainCnt_q == RC_M1) begin
            mainSt_q <= cmac_pkg::ST_GAP;
            mainCnt_q <= 7'h00;
          end else begin
            mainCnt_q <= mainCnt_q + 7'h01;
          end
        end
        cmac_pkg::ST_GAP: begin
          mainSt_q <= cmac_pkg::ST_WRITE;
        end
        cmac_pkg::ST_WRITE: begin
          if (mainCnt_q == WC_M1) begin
            mainSt_q <= cmac_pkg::ST_IDLE;
          end else begin
            mainCnt_q <= mainCnt_q + 7'h01;
          end
        end
        default: mainSt_q <= cmac_pkg::ST_IDLE;
      endcase
    end
  end

  // Next address: loaded at request, special bits forced in phase 1.
  // The line selects decode this same value, so they never lag the register by a cycle.
  always_comb begin
    mainAddrD = main_addr_reg;
    if (mainSt_q == cmac_pkg::ST_IDLE && mainStart) begin
      mainAddrD = mainSrc;
    end else if (mainSt_q == cmac_pkg::ST_READ && mainCnt_q == 7'h00) begin
      if (specialSel[0]) mainAddrD[cmac_pkg::SPECIAL0] = 1'b1;
      if (specialSel[1]) mainAddrD[cmac_pkg::SPECIAL6] = 1'b1;
      if (specialSel[2]) mainAddrD[cmac_pkg::SPECIAL8] = 1'b1;
    end
  end

  // Main address register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_addr_reg <= 16'h0000;
    end else begin
      main_addr_reg <= mainAddrD;
    end
  end

  // Main data register: sensed word captured at end of read, or replaced.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_data_reg <= cmac_pkg::DATA_RST;
    end else if (mainSt_q == cmac_pkg::ST_READ && mainCnt_q == RC_M1) begin
      main_data_reg <= mainSense;
    end else if (mainSt_q == cmac_pkg::ST_GAP && mainReplace) begin
      main_data_reg <= mainNewData;
    end
  end

  // Drive outputs; the gap state keeps read and write enables apart.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bankReadEn <= 4'h0;
      bankWriteEn <= 4'h0;
      stackSel <= 4'h0;
      xGroupSel <= 8'h00;
      xLineSel <= 8'h00;
      yGroupSel <= 8'h00;
      yLineSel <= 8'h00;
      inhibit <= 18'h00000;
      mainBusy <= 1'b0;
      mainDone <= 1'b0;
    end else begin
      bankReadEn <= (mainSt_q == cmac_pkg::ST_READ && bankOk) ? bankHot : 4'h0;
      bankWriteEn <= (mainSt_q == cmac_pkg::ST_WRITE && bankOk) ? bankHot : 4'h0;
      stackSel <= dec4(mainAddrD[cmac_pkg::BIT_STACK +: 2]);
      xGroupSel <= dec8(mainAddrD[cmac_pkg::BIT_XGRP +: 3]);
      xLineSel <= dec8(mainAddrD[cmac_pkg::BIT_XLINE +: 3]);
      yGroupSel <= dec8(mainAddrD[cmac_pkg::BIT_YGRP +: 3]);
      yLineSel <= dec8(mainAddrD[cmac_pkg::BIT_YLINE +: 3]);
      inhibit <= (mainSt_q == cmac_pkg::ST_WRITE) ? ~main_data_reg : 18'h00000;
      mainBusy <= (mainSt_q != cmac_pkg::ST_IDLE) || mainStart;
      mainDone <= mainSt_q == cmac_pkg::ST_WRITE && mainCnt_q == WC_M1;
    end
  end

  // Control sequencer; bootstrap addresses skip the write cycle entirely.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctlSt_q <= cmac_pkg::ST_IDLE;
      ctlCnt_q <= 7'h00;
    end else begin
      case (ctlSt_q)
        cmac_pkg::ST_IDLE: begin
          ctlCnt_q <= 7'h00;
          if (ctlStart) begin
            ctlSt_q <= cmac_pkg::ST_READ;
          end
        end
        cmac_pkg::ST_READ: begin
          if (ctlCnt_q == RC_M1) begin
            ctlSt_q <= isBoot_q ? cmac_pkg::ST_IDLE : cmac_pkg::ST_GAP;
            ctlCnt_q <= 7'h00;
          end else begin
            ctlCnt_q <= ctlCnt_q + 7'h01;
          end
        end
        cmac_pkg::ST_GAP: begin
          ctlSt_q <= cmac_pkg::ST_WRITE;
        end
        cmac_pkg::ST_WRITE: begin
          if (ctlCnt_q == WC_M1) begin
            ctlSt_q <= cmac_pkg::ST_IDLE;
          end else begin
            ctlCnt_q <= ctlCnt_q + 7'h01;
          end
        end
        default: ctlSt_q <= cmac_pkg::ST_IDLE;
      endcase
    end
  end

  // Control address: 0..127 control memory, 128..159 bootstrap, above unused.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_addr_reg <= 8'h00;
      isBoot_q <= 1'b0;
    end else if (ctlSt_q == cmac_pkg::ST_IDLE && ctlStart) begin
      ctl_addr_reg <= ctlSrc;
      isBoot_q <= ctlSrc[7];
    end
  end

  // Control data register fills from sense or bootstrap, then may be replaced.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_data_reg <= cmac_pkg::DATA_RST;
    end else if (ctlSt_q == cmac_pkg::ST_READ && ctlCnt_q == RC_M1) begin
      ctl_data_reg <= isBoot_q ? bootWord : ctlSense;
    end else if (ctlSt_q == cmac_pkg::ST_GAP && ctlReplace) begin
      ctl_data_reg <= ctlNewData;
    end
  end

  // Control and bootstrap drive outputs.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctlReadEn <= 1'b0;
      ctlWriteEn <= 1'b0;
      ctlInhibit <= 18'h00000;
      bootReadEn <= 1'b0;
      ctlBusy <= 1'b0;
      ctlDone <= 1'b0;
    end else begin
      ctlReadEn <= ctlSt_q == cmac_pkg::ST_READ && !isBoot_q;
      bootReadEn <= ctlSt_q == cmac_pkg::ST_READ && isBoot_q && ctl_addr_reg[6:5] == 2'h0;
      ctlWriteEn <= ctlSt_q == cmac_pkg::ST_WRITE;
      ctlInhibit <= (ctlSt_q == cmac_pkg::ST_WRITE) ? ~ctl_data_reg : 18'h00000;
      ctlBusy <= (ctlSt_q != cmac_pkg::ST_IDLE) || ctlStart;
      ctlDone <= (ctlSt_q == cmac_pkg::ST_WRITE && ctlCnt_q == WC_M1)
        || (ctlSt_q == cmac_pkg::ST_READ && isBoot_q && ctlCnt_q == RC_M1);
    end
  end
endmodule

// ==== tb/cmac_core_asserts.sv ====
`timescale 1ns/1ns
module cmac_core_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mainReplace,
  input wire logic [17:0] mainNewData,
  input wire logic [15:0] main_addr_reg,
  input wire logic [17:0] main_data_reg,
  input wire logic [3:0] bankReadEn,
  input wire logic [3:0] bankWriteEn,
  input wire logic [3:0] stackSel,
  input wire logic [7:0] xGroupSel,
  input wire logic [7:0] xLineSel,
  input wire logic [7:0] yGroupSel,
  input wire logic [7:0] yLineSel,
  input wire logic [17:0] inhibit,
  input wire logic mainDone,
  input wire logic ctlReadEn,
  input wire logic ctlWriteEn,
  input wire logic bootReadEn
);
  logic [5:0] rdCnt_q;
  logic [5:0] wrCnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Phase spans are too long for a repetition, so each is counted and judged when it ends.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdCnt_q <= 6'h00;
      wrCnt_q <= 6'h00;
    end else begin
      rdCnt_q <= (|bankReadEn) ? rdCnt_q + 6'h01 : 6'h00;
      wrCnt_q <= (|bankWriteEn) ? wrCnt_q + 6'h01 : 6'h00;
    end
  end
  // The gap keeps both drivers off before the same bank is written.
  sequence gapCycle; bankWriteEn == 4'h0; endsequence
  sequence sameBankWrite; bankWriteEn == $past(bankReadEn, 2); endsequence
  rw_exclusive_a: assert property (!((|bankReadEn) && (|bankWriteEn)))
    else $error("read and write enables overlap");
  gap_write_a: assert property ($fell(|bankReadEn) |-> gapCycle ##1 sameBankWrite)
    else $error("write does not follow read in the same bank");
  read_len_a: assert property (!(|bankReadEn) && rdCnt_q != 6'h00 |-> rdCnt_q == 15)
    else $error("read phase length wrong");
  write_len_a: assert property (!(|bankWriteEn) && wrCnt_q != 6'h00 |-> wrCnt_q == 25)
    else $error("write phase length wrong");
  bank_decode_a: assert property (|bankReadEn |-> bankReadEn == (4'h1 << main_addr_reg[15:14]))
    else $error("bank decode wrong");
  xline_decode_a: assert property (|bankReadEn |-> xGroupSel == (8'h1 << main_addr_reg[8:6])
    && xLineSel == (8'h1 << main_addr_reg[11:9])) else $error("x select wrong");
  yline_decode_a: assert property (|bankWriteEn |-> yGroupSel == (8'h1 << main_addr_reg[2:0])
    && yLineSel == (8'h1 << main_addr_reg[5:3]) && stackSel == (4'h1 << main_addr_reg[13:12]))
    else $error("y or stack select wrong");
  zero_inhibit_a: assert property (|bankWriteEn |-> inhibit == ~main_data_reg)
    else $error("inhibit does not follow zero bits");
  replace_data_a: assert property (|bankWriteEn && mainReplace |-> main_data_reg == mainNewData)
    else $error("replacement word not written");
  boot_nowrite_a: assert property ($fell(bootReadEn) |-> !ctlWriteEn [*8])
    else $error("write issued after bootstrap read");
  ctl_exclusive_a: assert property (!(ctlReadEn && ctlWriteEn))
    else $error("control read and write overlap");
  done_after_a: assert property ($fell(|bankWriteEn) |-> $past(mainDone) && !mainDone)
    else $error("done missing after write");
endmodule
bind cmac_core cmac_core_asserts i_chk (.core_clk, .rst, .mainReplace, .mainNewData,
  .main_addr_reg, .main_data_reg, .bankReadEn, .bankWriteEn, .stackSel, .xGroupSel,
  .xLineSel, .yGroupSel, .yLineSel, .inhibit, .mainDone, .ctlReadEn, .ctlWriteEn, .bootReadEn);

// ==== tb/cmac_stacks_model.sv ====
`timescale 1ns/1ns
module cmac_stacks_model (
  input wire logic core_clk,
  input wire logic [15:0] main_addr_reg,
  input wire logic [3:0] bankReadEn,
  input wire logic [3:0] bankWriteEn,
  input wire logic [17:0] inhibit,
  output logic [17:0] mainSense,
  input wire logic [7:0] ctl_addr_reg,
  input wire logic ctlReadEn,
  input wire logic ctlWriteEn,
  input wire logic [17:0] ctlInhibit,
  input wire logic bootReadEn,
  output logic [17:0] ctlSense,
  output logic [17:0] bootWord
);
  logic [17:0] mainMem [0:65535];
  logic [17:0] ctlMem [0:127];
  logic [17:0] mainHeld;
  logic [17:0] ctlHeld;
  logic mainRd;
  logic ctlRd;
  // A read wipes the word, so a design that skips the write-back loses it.
  always @(posedge core_clk) begin
    mainRd <= |bankReadEn;
    ctlRd <= ctlReadEn;
    if ((|bankReadEn) && !mainRd) begin
      mainHeld <= mainMem[main_addr_reg];
      mainMem[main_addr_reg] <= 18'h00000;
    end
    if (ctlReadEn && !ctlRd) begin
      ctlHeld <= ctlMem[ctl_addr_reg[6:0]];
      ctlMem[ctl_addr_reg[6:0]] <= 18'h00000;
    end
    if (|bankWriteEn) mainMem[main_addr_reg] <= ~inhibit;
    if (ctlWriteEn) ctlMem[ctl_addr_reg[6:0]] <= ~ctlInhibit;
  end
  // Outside a read the lines show the inverse, so a badly timed sample is caught.
  assign mainSense = mainRd ? mainHeld : ~mainHeld;
  assign ctlSense = ctlRd ? ctlHeld : ~ctlHeld;
  assign bootWord = bootReadEn ? {ctl_addr_reg, 10'h155} : ~{ctl_addr_reg, 10'h155};
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errorCnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  logic core_clk, rst, mainStart, mainReplace, ctlStart, ctlReplace, mainBusy, mainDone;
  logic ctlReadEn, ctlWriteEn, bootReadEn, ctlBusy, ctlDone;
  logic [1:0] mainSrcSel, ctlSrcSel;
  logic [2:0] specialSel;
  logic [3:0] bankReadEn, bankWriteEn, stackSel;
  logic [7:0] indexCtlReg, ioCtlAddr, arithCtlAddr, ctl_addr_reg;
  logic [7:0] xGroupSel, xLineSel, yGroupSel, yLineSel;
  logic [15:0] progCounter, indexReg, ioAddr, adderAddr, main_addr_reg;
  logic [17:0] mainNewData, mainSense, ctlNewData, ctlSense, bootWord;
  logic [17:0] main_data_reg, inhibit, ctl_data_reg, ctlInhibit;
  int errorCnt = 0;
  int samplesChecked = 0;
  cmac_core i_dut (.core_clk, .rst, .mainStart, .mainSrcSel, .progCounter, .indexReg, .ioAddr,
    .adderAddr, .specialSel, .mainReplace, .mainNewData, .mainSense, .ctlStart, .ctlSrcSel,
    .indexCtlReg, .ioCtlAddr, .arithCtlAddr, .ctlReplace, .ctlNewData, .ctlSense, .bootWord,
    .main_addr_reg, .main_data_reg, .bankReadEn, .bankWriteEn, .stackSel, .xGroupSel, .xLineSel,
    .yGroupSel, .yLineSel, .inhibit, .mainBusy, .mainDone, .ctl_addr_reg, .ctl_data_reg,
    .ctlReadEn, .ctlWriteEn, .ctlInhibit, .bootReadEn, .ctlBusy, .ctlDone);
  cmac_stacks_model i_mem (.core_clk, .main_addr_reg, .bankReadEn, .bankWriteEn, .inhibit,
    .mainSense, .ctl_addr_reg, .ctlReadEn, .ctlWriteEn, .ctlInhibit, .bootReadEn, .ctlSense,
    .bootWord);
  task automatic finalReport;
    if (errorCnt == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A lost done pulse would hang the run, so the wait is bounded.
  task automatic waitDone(input bit ctl);
    int n = 0;
    while ((ctl ? ctlDone : mainDone) !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if ((ctl ? ctlDone : mainDone) !== 1'b1) begin
      `CHK("done", 1'b1, 1'b0)
      finalReport();
    end
    @(negedge core_clk);
  endtask
  // Unselected sources carry the inverse so a wrong source pick shows up.
  task automatic mainOp(input logic [1:0] s, input logic [15:0] a, input logic [2:0] sp,
                        input logic r, input logic [17:0] nd);
    @(negedge core_clk);
    {progCounter, indexReg} = {(s == 2'h0) ? a : ~a, (s == 2'h1) ? a : ~a};
    {ioAddr, adderAddr} = {(s == 2'h2) ? a : ~a, (s == 2'h3) ? a : ~a};
    {mainSrcSel, specialSel, mainReplace, mainNewData, mainStart} = {s, sp, r, nd, 1'b1};
    @(negedge core_clk);
    mainStart = 1'b0;
    `CHK("mainBusy", 1'b1, mainBusy)
    waitDone(1'b0);
    `CHK("mainBusy", 1'b0, mainBusy)
  endtask
  task automatic ctlOp(input logic [1:0] s, input logic [7:0] a, input logic r,
                       input logic [17:0] nd);
    @(negedge core_clk);
    {indexCtlReg, ioCtlAddr} = {(s == 2'h1) ? a : ~a, (s == 2'h2) ? a : ~a};
    arithCtlAddr = (s == 2'h3) ? a : ~a;
    {ctlSrcSel, ctlReplace, ctlNewData, ctlStart} = {s, r, nd, 1'b1};
    @(negedge core_clk);
    ctlStart = 1'b0;
    `CHK("ctlBusy", 1'b1, ctlBusy)
    waitDone(1'b1);
    `CHK("ctlBusy", 1'b0, ctlBusy)
  endtask
  task automatic scenMainWrite;
    mainOp(2'h3, 16'h8abc, 3'h0, 1'b1, 18'h2a5c3);
    `CHK("main_addr_reg", 16'h8abc, main_addr_reg)
    `CHK("main_data_reg", 18'h2a5c3, main_data_reg)
  endtask
  // Two plain reads in a row: the second only matches if the first restored the word.
  task automatic scenRestore;
    repeat (2) begin
      mainOp(2'h0, 16'h8abc, 3'h0, 1'b0, 18'h00000);
      `CHK("main_data_reg", 18'h2a5c3, main_data_reg)
    end
  endtask
  task automatic scenSpecial;
    mainOp(2'h1, 16'hc000, 3'h7, 1'b1, 18'h0f0f0);
    `CHK("main_addr_reg", 16'hc141, main_addr_reg)
    mainOp(2'h2, 16'hc141, 3'h0, 1'b0, 18'h00000);
    `CHK("main_data_reg", 18'h0f0f0, main_data_reg)
  endtask
  task automatic scenCtl;
    ctlOp(2'h0, 8'h41, 1'b1, 18'h1b2c3);
    `CHK("ctl_addr_reg", 8'h41, ctl_addr_reg)
    ctlOp(2'h1, 8'h41, 1'b0, 18'h00000);
    ctlOp(2'h2, 8'h41, 1'b0, 18'h00000);
    `CHK("ctl_data_reg", 18'h1b2c3, ctl_data_reg)
  endtask
  task automatic scenBoot;
    repeat (2) begin
      ctlOp(2'h3, 8'h83, 1'b0, 18'h00000);
      `CHK("ctl_data_reg", {8'h83, 10'h155}, ctl_data_reg)
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {rst, mainStart, mainReplace, ctlStart, ctlReplace, mainSrcSel, ctlSrcSel} = 9'h100;
    {specialSel, progCounter, indexReg, ioAddr, adderAddr, mainNewData, ctlNewData} = '0;
    {indexCtlReg, ioCtlAddr, arithCtlAddr} = '0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    scenMainWrite();
    scenRestore();
    scenSpecial();
    scenCtl();
    scenBoot();
    finalReport();
  end
endmodule
